// *** inc/dagcr_defs.svh ***
`ifndef DAGCR_DEFS_SVH
`define DAGCR_DEFS_SVH

// register address space
`define DAGCR_GLOB_CFG_ADDR 7'h00
`define DAGCR_WRITE_FLAG 8'h80
`define DAGCR_GLOB_CFG_W 11
`define DAGCR_GLOB_CFG_RESET 11'h000

// global configuration field positions
`define DAGCR_BIT_SINGLE_DRIVER 0
`define DAGCR_BIT_RSVD_LO 1
`define DAGCR_BIT_RSVD_HI 2
`define DAGCR_BIT_POSCMP 3
`define DAGCR_BIT_IDX_SRC 4
`define DAGCR_BIT_SHAFT1 8
`define DAGCR_BIT_SHAFT2 9
`define DAGCR_BIT_LOCK 10

// pin input synchroniser depth
`define DAGCR_SYNC_STAGES 3

`endif

// *** inc/dagcr_pkg.sv ***
package dagcr_pkg;

  // global configuration layout, msb first
  typedef struct packed {
    logic lock;
    logic shaft2;
    logic shaft1;
    logic test_mode;
    logic enc2_refsel;
    logic enc2_enable;
    logic encoder_one_index_source;
    logic poscmp_enable;
    logic [1:0] reserved;
    logic single_driver;
  } dagcr_glob_cfg_t;

  // one register access from the serial front end
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dagcr_req_t;

  // answer to a register access
  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] rdata;
  } dagcr_rsp_t;

  // per-driver control bundle
  typedef struct packed {
    logic enable;
    logic [3:0] phase;
  } dagcr_drv_t;

endpackage

// *** testbench/dagcr_top_tb.sv ***
`timescale 1ns/1ps
// one compare: counts every check, reports and counts a mismatch
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module dagcr_top_tb;
  logic clk;
  logic rst;
  dagcr_pkg::dagcr_req_t req;
  dagcr_pkg::dagcr_rsp_t rsp;
  dagcr_pkg::dagcr_glob_cfg_t cfg;
  dagcr_pkg::dagcr_drv_t drv1_cmd;
  dagcr_pkg::dagcr_drv_t drv2_cmd;
  dagcr_pkg::dagcr_drv_t drv1_out;
  dagcr_pkg::dagcr_drv_t drv2_out;
  logic motor1_dir_invert;
  logic motor2_dir_invert;
  logic interface_select;
  logic enc1_a_i;
  logic enc1_b_i;
  logic serial_wire_positive;
  logic io0_i;
  logic left_limit_input_axis1;
  logic position_pulse_out;
  logic irq_src;
  logic enc1_a;
  logic enc1_b;
  logic enc1_index;
  logic enc1_a_o;
  logic enc1_a_oe;
  logic enc1_b_o;
  logic enc1_b_oe;
  int n_fail;
  int n_checks;

  dagcr_top u_dagcr_top (
    .clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .global_configuration(cfg),
    .drv1_cmd(drv1_cmd), .drv2_cmd(drv2_cmd),
    .drv1_out(drv1_out), .drv2_out(drv2_out),
    .motor1_dir_invert(motor1_dir_invert),
    .motor2_dir_invert(motor2_dir_invert),
    .interface_select(interface_select), .enc1_a_i(enc1_a_i),
    .enc1_b_i(enc1_b_i), .serial_wire_positive(serial_wire_positive),
    .io0_i(io0_i), .left_limit_input_axis1(left_limit_input_axis1),
    .position_pulse_out(position_pulse_out), .irq_src(irq_src),
    .enc1_a(enc1_a), .enc1_b(enc1_b), .enc1_index(enc1_index),
    .enc1_a_o(enc1_a_o), .enc1_a_oe(enc1_a_oe),
    .enc1_b_o(enc1_b_o), .enc1_b_oe(enc1_b_oe)
  );

  // 25 mhz system clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // inputs always move 1 ns after the edge to stay clear of sampling
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task do_reset();
    rst = 1'b1;
    step(10);
    rst = 0;
  endtask

  // one register access; answer is registered, seen one edge later
  task acc(input logic [7:0] a, input logic [31:0] d);
    step(1);
    req.valid = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.valid = 1'b0;
    `CHK("rsp_valid", 1'b1, rsp.valid)
  endtask

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task t_reset();
    `CHK("cfg", 11'h000, cfg)
    `CHK("a_oe", 1'b0, enc1_a_oe)
    acc(8'h00, 32'h0);
    `CHK("rdata", 32'h0, rsp.rdata)
  endtask

  // reserved bits 1 and 2 kept zero in every write below
  task t_write_read();
    acc(8'h80, 32'hffff_f0f1);
    `CHK("w_hit", 1'b1, rsp.hit)
    `CHK("cfg", 11'h0f1, cfg)
    acc(8'h00, 32'h0000_0300);
    `CHK("rdata", 32'h0f1, rsp.rdata)
    `CHK("cfg", 11'h0f1, cfg)
    acc(8'h05, 32'h0);
    `CHK("u_hit", 1'b0, rsp.hit)
    `CHK("u_rdata", 32'h0, rsp.rdata)
    acc(8'h85, 32'h0);
    `CHK("cfg", 11'h0f1, cfg)
  endtask

  // mode set while drivers are idle, then traffic applied
  task t_single();
    drv1_cmd = '0;
    drv2_cmd = '0;
    acc(8'h80, 32'h101);
    drv1_cmd = 5'h15;
    drv2_cmd = 5'h0a;
    step(1);
    `CHK("drv1", 5'h15, drv1_out)
    `CHK("drv2", 5'h15, drv2_out)
    `CHK("m1_inv", 1'b1, motor1_dir_invert)
    `CHK("m2_inv", 1'b1, motor2_dir_invert)
    drv1_cmd = '0;
    drv2_cmd = '0;
    acc(8'h80, 32'h200);
    drv1_cmd = 5'h15;
    drv2_cmd = 5'h0a;
    step(1);
    `CHK("drv2", 5'h0a, drv2_out)
    `CHK("m1_inv", 1'b0, motor1_dir_invert)
    `CHK("m2_inv", 1'b1, motor2_dir_invert)
  endtask

  task t_poscmp();
    enc1_a_i = 1'b1;
    enc1_b_i = 1'b1;
    position_pulse_out = 1'b1;
    irq_src = 1'b0;
    acc(8'h80, 32'h008);
    step(1);
    `CHK("a_oe", 1'b1, enc1_a_oe)
    `CHK("b_oe", 1'b1, enc1_b_oe)
    `CHK("a_o", 1'b1, enc1_a_o)
    `CHK("b_o", 1'b0, enc1_b_o)
    position_pulse_out = 1'b0;
    irq_src = 1'b1;
    step(8);
    `CHK("a_o", 1'b0, enc1_a_o)
    `CHK("b_o", 1'b1, enc1_b_o)
    `CHK("enc_a", 1'b0, enc1_a)
    `CHK("enc_b", 1'b0, enc1_b)
    acc(8'h80, 32'h0);
    step(8);
    `CHK("a_oe", 1'b0, enc1_a_oe)
    `CHK("b_oe", 1'b0, enc1_b_oe)
    `CHK("enc_a", 1'b1, enc1_a)
    `CHK("enc_b", 1'b1, enc1_b)
  endtask

  // each source tried low then high, the others opposite
  task t_index();
    logic v;
    int c;
    for (int k = 0; k < 6; k++) begin
      v = k[0];
      c = k / 2;
      interface_select = (c == 1);
      serial_wire_positive = (c == 0) ? v : !v;
      io0_i = (c == 1) ? v : !v;
      left_limit_input_axis1 = (c == 2) ? v : !v;
      // select level is followed at any time through the strap filter; each mode still starts from reset
      if (!v) begin
        do_reset();
      end
      acc(8'h80, (c == 2) ? 32'h010 : 32'h000);
      step(8);
      `CHK("index", v, enc1_index)
    end
  endtask

  task t_lock();
    acc(8'h80, 32'h401);
    acc(8'h80, 32'h000);
    `CHK("cfg", 11'h401, cfg)
    do_reset();
    `CHK("cfg", 11'h000, cfg)
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    req = '0;
    drv1_cmd = '0;
    drv2_cmd = '0;
    interface_select = 1'b0;
    enc1_a_i = 1'b0;
    enc1_b_i = 1'b0;
    serial_wire_positive = 1'b0;
    io0_i = 1'b0;
    left_limit_input_axis1 = 1'b0;
    position_pulse_out = 1'b0;
    irq_src = 1'b0;
    do_reset();
    t_reset();
    t_write_read();
    t_single();
    t_poscmp();
    t_index();
    t_lock();
    complete_run();
  end
endmodule // dagcr_top_tb

// *** verilog/dagcr_pinmux.sv ***
`timescale 1ns/1ps
`include "dagcr_defs.svh"

module dagcr_pinmux (
  input wire logic clk,
  input wire logic rst,
  input wire logic poscmp_en,
  input wire logic index_src_sel,
  input wire logic interface_select,
  input wire logic enc1_a_i,
  input wire logic enc1_b_i,
  input wire logic serial_wire_positive,
  input wire logic io0_i,
  input wire logic left_limit_input_axis1,
  input wire logic position_pulse_out,
  input wire logic irq_src,
  output logic enc1_a,
  output logic enc1_b,
  output logic enc1_index,
  output logic enc1_a_o,
  output logic enc1_a_oe,
  output logic enc1_b_o,
  output logic enc1_b_oe
);

  localparam int NPIN = 5;
  localparam int P_A = 0;
  localparam int P_B = 1;
  localparam int P_SW = 2;
  localparam int P_IO0 = 3;
  localparam int P_REFL = 4;

  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] flt_q;
  logic [NPIN-1:0] flt_d;
  logic idx_d;

  assign raw = {left_limit_input_axis1, io0_i, serial_wire_positive,
                enc1_b_i, enc1_a_i};

  // accept a change only once stages two and three agree
  assign flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);

  // three-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // index source: reference switch or interface-dependent pin
  assign idx_d = index_src_sel ? flt_q[P_REFL] : // [R7]
                 (interface_select ? flt_q[P_IO0] : flt_q[P_SW]);

  // pin ownership follows the compare enable
  always_ff @(posedge clk) begin
    if (rst) begin
      enc1_a <= 1'b0;
      enc1_b <= 1'b0;
      enc1_index <= 1'b0;
      enc1_a_o <= 1'b0;
      enc1_a_oe <= 1'b0;
      enc1_b_o <= 1'b0;
      enc1_b_oe <= 1'b0;
    end else begin
      enc1_a <= poscmp_en ? 1'b0 : flt_q[P_A]; // [R6]
      enc1_b <= poscmp_en ? 1'b0 : flt_q[P_B]; // [R6]
      enc1_index <= idx_d; // [R7]
      enc1_a_o <= poscmp_en & position_pulse_out; // [R6]
      enc1_b_o <= poscmp_en & irq_src; // [R6]
      enc1_a_oe <= poscmp_en; // [R6]
      enc1_b_oe <= poscmp_en; // [R6]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_index_refl: assert property ( // [R7]
    index_src_sel |=> enc1_index == $past(flt_q[P_REFL]))
    else $error("index not taken from left limit");
  chk_index_iface: assert property ( // [R7]
    !index_src_sel && !interface_select |=> enc1_index == $past(flt_q[P_SW]))
    else $error("index not taken from serial wire pin");
  chk_index_io: assert property ( // [R7]
    !index_src_sel && interface_select |=> enc1_index == $past(flt_q[P_IO0]))
    else $error("index not taken from io pin");
  chk_filter_agree: assert property ( // [R6]
    s2_q[P_A] != s3_q[P_A] |=> flt_q[P_A] == $past(flt_q[P_A]))
    else $error("filter changed while stages disagree");

endmodule // dagcr_pinmux

// *** verilog/dagcr_top.sv ***
`timescale 1ns/1ps
`include "dagcr_defs.svh"
// Functional notes
// R1: at reset every register bit is cleared to zero.
// R2: an address with 0x80 added is a write to the register at the base.
// R3: single-driver bit set makes driver 2 copy driver 1, ignoring its own.
// R4: software sets the single-driver bit before enabling the drivers.
// R5: software always writes zero to reserved bits 1 and 2.
// R6: compare bit set turns encoder 1 A/B pins into pulse and irq outputs.
// R7: bit 4 picks index from left limit, else serial wire or io pin.
// R8: an address byte with msb clear reads the register and changes nothing.

module dagcr_top (
  input wire logic clk,
  input wire logic rst,
  input wire dagcr_pkg::dagcr_req_t req,
  output dagcr_pkg::dagcr_rsp_t rsp,
  output dagcr_pkg::dagcr_glob_cfg_t global_configuration,
  input wire dagcr_pkg::dagcr_drv_t drv1_cmd,
  input wire dagcr_pkg::dagcr_drv_t drv2_cmd,
  output dagcr_pkg::dagcr_drv_t drv1_out,
  output dagcr_pkg::dagcr_drv_t drv2_out,
  output logic motor1_dir_invert,
  output logic motor2_dir_invert,
  input wire logic interface_select,
  input wire logic enc1_a_i,
  input wire logic enc1_b_i,
  input wire logic serial_wire_positive,
  input wire logic io0_i,
  input wire logic left_limit_input_axis1,
  input wire logic position_pulse_out,
  input wire logic irq_src,
  output logic enc1_a,
  output logic enc1_b,
  output logic enc1_index,
  output logic enc1_a_o,
  output logic enc1_a_oe,
  output logic enc1_b_o,
  output logic enc1_b_oe
);

  dagcr_pkg::dagcr_glob_cfg_t global_configuration_q;
  dagcr_pkg::dagcr_glob_cfg_t global_configuration_d;
  dagcr_pkg::dagcr_glob_cfg_t cfg;
  dagcr_pkg::dagcr_rsp_t rsp_q;
  dagcr_pkg::dagcr_rsp_t rsp_d;
  dagcr_pkg::dagcr_drv_t drv1_q;
  dagcr_pkg::dagcr_drv_t drv2_q;
  dagcr_pkg::dagcr_drv_t drv2_d;
  logic m1_inv_q;
  logic m2_inv_q;
  logic iface_s1_q;
  logic iface_s2_q;
  logic iface_s3_q;
  logic iface_sel_q;
  logic iface_sel_d;
  logic is_write;
  logic hit;
  logic cfg_wr;

  // address byte decode: msb selects write, low seven bits the register
  function automatic logic addr_hits_cfg(input logic [7:0] a);
    addr_hits_cfg = (a[6:0] == `DAGCR_GLOB_CFG_ADDR);
  endfunction

  // short alias keeps the decode and the checks below readable
  assign cfg = global_configuration_q;
  assign is_write = req.valid & req.addr[7]; // [R2]
  assign hit = addr_hits_cfg(req.addr);
  // lock bit freezes the register against later writes
  assign cfg_wr = is_write & hit & ~cfg.lock; // [R2]
  assign global_configuration_d = cfg_wr ?
    dagcr_pkg::dagcr_glob_cfg_t'(req.wdata[`DAGCR_GLOB_CFG_W-1:0]) : cfg;

  // reads return the register zero-extended, unmapped reads return zero
  assign rsp_d.valid = req.valid;
  assign rsp_d.hit = req.valid & hit;
  assign rsp_d.rdata = (req.valid & ~req.addr[7] & hit) ? // [R8]
    {21'h0, cfg} : 32'h00000000;

  // configuration register, cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      global_configuration_q <=
        dagcr_pkg::dagcr_glob_cfg_t'(`DAGCR_GLOB_CFG_RESET); // [R1]
    end else begin
      global_configuration_q <= global_configuration_d; // [R2] [R8]
    end
  end

  // answer register, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // single-driver mode: driver 2 mirrors driver 1 and its own controls drop
  // out; switching this live glitches the bridges, so set it first
  assign drv2_d = cfg.single_driver ? drv1_cmd : drv2_cmd; // [R3]

  always_ff @(posedge clk) begin
    if (rst) begin
      drv1_q <= '0;
      drv2_q <= '0;
      m1_inv_q <= 1'b0;
      m2_inv_q <= 1'b0;
    end else begin
      drv1_q <= drv1_cmd;
      drv2_q <= drv2_d; // [R3]
      m1_inv_q <= cfg.shaft1;
      m2_inv_q <= cfg.single_driver ? cfg.shaft1 : cfg.shaft2; // [R3]
    end
  end

  // strap pin is asynchronous: three flops, and a change only counts once
  // the last two agree, so a bouncing strap cannot flip the index source
  assign iface_sel_d = (iface_s2_q == iface_s3_q) ? iface_s3_q : iface_sel_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      iface_s1_q <= 1'b0;
      iface_s2_q <= 1'b0;
      iface_s3_q <= 1'b0;
      iface_sel_q <= 1'b0;
    end else begin
      iface_s1_q <= interface_select;
      iface_s2_q <= iface_s1_q;
      iface_s3_q <= iface_s2_q;
      iface_sel_q <= iface_sel_d; // [R7]
    end
  end

  dagcr_pinmux u_pinmux (
    .clk(clk),
    .rst(rst),
    .poscmp_en(cfg.poscmp_enable),
    .index_src_sel(cfg.encoder_one_index_source),
    .interface_select(iface_sel_q),
    .enc1_a_i(enc1_a_i),
    .enc1_b_i(enc1_b_i),
    .serial_wire_positive(serial_wire_positive),
    .io0_i(io0_i),
    .left_limit_input_axis1(left_limit_input_axis1),
    .position_pulse_out(position_pulse_out),
    .irq_src(irq_src),
    .enc1_a(enc1_a),
    .enc1_b(enc1_b),
    .enc1_index(enc1_index),
    .enc1_a_o(enc1_a_o),
    .enc1_a_oe(enc1_a_oe),
    .enc1_b_o(enc1_b_o),
    .enc1_b_oe(enc1_b_oe)
  );

  assign rsp = rsp_q;
  assign global_configuration = global_configuration_q;
  assign drv1_out = drv1_q;
  assign drv2_out = drv2_q;
  assign motor1_dir_invert = m1_inv_q;
  assign motor2_dir_invert = m2_inv_q;

  default clocking cb @(posedge clk); endclocking

  // this one must look while reset is high, so it opts out of the default
  chk_reset_clears: assert property ( // [R1]
    @(posedge clk) disable iff (1'b0) rst |=> cfg == '0 && rsp_q == '0)
    else $error("reset left register nonzero");

  default disable iff (rst);

  // register port: writes, lock, reads and the one-cycle answer
  chk_write_stores: assert property ( // [R2]
    req.valid && req.addr == (`DAGCR_WRITE_FLAG | 8'h00) && !cfg.lock
    |=> cfg == $past(req.wdata[`DAGCR_GLOB_CFG_W-1:0]))
    else $error("write to register not stored");
  chk_unmapped_write: assert property ( // [R2]
    req.valid && req.addr[7] && req.addr[6:0] != `DAGCR_GLOB_CFG_ADDR
    |=> $stable(cfg))
    else $error("write to other index changed register");
  chk_lock_holds: assert property ( // [R2]
    cfg.lock |=> $stable(cfg))
    else $error("locked register changed");
  chk_read_stable: assert property ( // [R8]
    req.valid && !req.addr[7] |=> $stable(cfg))
    else $error("read changed register");
  chk_read_data: assert property ( // [R8]
    req.valid && req.addr == 8'h00 |=> rsp.valid && rsp.hit &&
    rsp.rdata == {21'h0, $past(cfg)})
    else $error("read data mismatch");
  chk_unmapped_read: assert property ( // [R8]
    req.valid && req.addr[6:0] != `DAGCR_GLOB_CFG_ADDR
    |=> !rsp.hit && rsp.rdata == 32'h00000000)
    else $error("unmapped access answered as a hit");
  chk_rsp_pulse: assert property ( // [R8]
    !req.valid |=> !rsp.valid)
    else $error("answer without a request");

  // driver 2 and motor 2 outputs follow the mode bit, driver 1 passes through
  chk_drv1_pass: assert property ( // [R3]
    1'b1 |=> drv1_out == $past(drv1_cmd))
    else $error("driver 1 not passed through");
  chk_single_follow: assert property ( // [R3]
    cfg.single_driver |=> drv2_out == $past(drv1_cmd))
    else $error("driver 2 not following driver 1");
  chk_dual_indep: assert property ( // [R3]
    !cfg.single_driver |=> drv2_out == $past(drv2_cmd))
    else $error("driver 2 not independent");
  chk_motor2_dir: assert property ( // [R3]
    cfg.single_driver |=> motor2_dir_invert == $past(cfg.shaft1))
    else $error("motor 2 direction not taken from motor 1");

  // encoder pins and the strap filter
  chk_pins_driven: assert property ( // [R6]
    cfg.poscmp_enable [*2] |=> enc1_a_oe && enc1_b_oe && !enc1_a && !enc1_b)
    else $error("compare pins not driven");
  chk_pins_released: assert property ( // [R6]
    !cfg.poscmp_enable |=> !enc1_a_oe && !enc1_b_oe)
    else $error("encoder pins driven in encoder mode");
  chk_iface_agree: assert property ( // [R7]
    iface_s2_q != iface_s3_q |=> iface_sel_q == $past(iface_sel_q))
    else $error("strap filter changed while stages disagree");

  cov_write: cover property (cfg_wr ##1 cfg.single_driver);
  cov_read: cover property (req.valid && !req.addr[7] && hit);
  cov_poscmp: cover property (cfg.poscmp_enable ##2 enc1_a_oe);
  cov_lock_block: cover property (cfg.lock && is_write && hit);
  cov_index_refl: cover property (cfg.encoder_one_index_source ##1 enc1_index);

endmodule // dagcr_top
